// ==== rtl/status_cmd_pkg.sv ====
// constants and carrier types of the status and command block
package status_cmd_pkg;

	// ************************************************************
	// command carrier
	// ************************************************************
	typedef enum logic [3:0] {
		OP_SETTING,
		OP_SELF_TEST,
		OP_CLEAR_STATUS,
		OP_OPC_ARM,
		OP_OPC_QUERY,
		OP_WAIT,
		OP_RESET,
		OP_EVENT_STATUS,
		OP_EVENT_ENABLE,
		OP_STATUS_BYTE,
		OP_SRQ_ENABLE,
		OP_PON_CLEAR
	} op_t;

	typedef struct packed {
		op_t         op;
		logic        query;
		logic [4:0]  sel;
		logic [15:0] arg;
	} cmd_t;

	// ************************************************************
	// status bit positions
	// ************************************************************
	localparam int ESR_OPC_BIT   = 0;
	localparam int ESR_QUERY_BIT = 2;
	localparam int ESR_DEV_BIT   = 3;
	localparam int ESR_EXEC_BIT  = 4;
	localparam int ESR_CMD_BIT   = 5;
	localparam int ESR_PON_BIT   = 7;
	localparam logic [7:0] ESR_USED_MASK = 8'hBD;
	localparam logic [7:0] ESR_RESET     = 8'h80;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_RQS_BIT = 6;

	// ************************************************************
	// replies and reset values
	// ************************************************************
	localparam logic [15:0] TST_PASS      = 16'h0000;
	localparam logic [15:0] TST_MEM_FAIL  = 16'h0001;
	localparam logic [15:0] OPC_DONE_REPLY = 16'h0001;
	localparam logic [7:0]  ESE_RESET     = 8'h00;
	localparam logic [7:0]  SRE_RESET     = 8'h00;
	localparam logic        PSC_RESET     = 1'b0;

	// ************************************************************
	// setting table: index, range, reset value
	// ************************************************************
	localparam int NUM_SET = 25;
	localparam int S_EXT_CTRL = 0;
	localparam int S_ANALOG   = 1;
	localparam int S_ADJ      = 2;
	localparam int S_PWRUP    = 3;
	localparam int S_TIME_UNIT_SELECT    = 4;
	localparam int S_LOOP_RATE_SELECT    = 5;
	localparam int S_PROGRAM_NUMBER     = 10;
	localparam int S_AUTORUN  = 11;
	localparam int S_CONNECT  = 24;
	localparam logic [15:0] LOOP_RATE_SELECT_A = 16'h0001;
	localparam logic [15:0] LOOP_RATE_SELECT_B = 16'h000A;
	localparam logic [15:0] LOOP_RATE_SELECT_C = 16'h0064;

	// ext, analog, adj, pwrup, time_unit_select, loop_rate_select, vhi, vlo, fhi, flo, program_number, autorun,
	// loopcycle, step, volt, freq, delay, dwell, chi, clo, phi, plo, power_factor_upper_limit, power_factor_lower_limit, connect
	localparam logic [15:0] SET_MIN [NUM_SET] = '{
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0001,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [15:0] SET_MAX [NUM_SET] = '{
		16'h0001, 16'h0003, 16'h0001, 16'h0002, 16'h0002, 16'h0064, 16'h270F,
		16'h270F, 16'h270F, 16'h270F, 16'h0008, 16'h0001, 16'h270F, 16'h0005,
		16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F,
		16'h270F, 16'h270F, 16'h270F, 16'h0001};
	// every setting resets to the bottom of its range
	localparam logic [15:0] SET_RESET [NUM_SET] = SET_MIN;

endpackage : status_cmd_pkg

// ==== rtl/setting_field.sv ====
// one range-checked setting register with its execution-error flag
module setting_field #(
	parameter int          W       = 16,
	parameter logic [15:0] MIN_VAL = 16'h0000,
	parameter logic [15:0] MAX_VAL = 16'h270F,
	parameter logic [15:0] RST_VAL = 16'h0000
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// write side
	input  wire logic         wr,
	input  wire logic         defaults,
	input  wire logic         extra_ok,
	input  wire logic [W-1:0] arg,
	// result
	output logic [W-1:0]      value_ff,
	output logic              bad
);

	// out-of-range writes leave the old value
	wire in_range = (arg >= MIN_VAL[W-1:0]) && (arg <= MAX_VAL[W-1:0]) && extra_ok;
	assign bad = wr && !in_range;

	// store on a good write, restore defaults on device reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			value_ff <= RST_VAL[W-1:0];
		end else if (defaults) begin
			value_ff <= RST_VAL[W-1:0];
		end else if (wr && in_range) begin
			value_ff <= arg;
		end
	end

endmodule // setting_field

// ==== rtl/status_cmd_core.sv ====
// command interpreter with event status, status byte and setting store

// How it works
// [RULE1] self-test replies 0x00 on pass, 0x01 on memory failure
// [RULE2] clear-status empties the event register
// [RULE3] clear-status drops request-service summary
// [RULE4] armed completion sets event bit 0 on output power-on
// [RULE5] event query returns one byte
// [RULE6] event bits 1 and 6 read zero
// [RULE7] query error is event bit 2
// [RULE8] device-specific error is event bit 3
// [RULE9] execution error is event bit 4
// [RULE10] command error is event bit 5
// [RULE11] power-on sets event bit 7
// [RULE12] event enable mask written and stored
// [RULE13] event enable query echoes the mask
// [RULE14] status bit 4 shows a waiting reply
// [RULE15] status bit 5 is the event summary
// [RULE16] status bit 6 is the request summary
// [RULE17] status query returns all bits, unassigned ones zero
// [RULE18] service request enable written and stored
// [RULE19] service enable query echoes the mask
// [RULE20] system-control codes decoded
// [RULE21] time unit, loop rate 1/10/100 and limits echoed
// [RULE22] program 1-8, step 1-5, delay/dwell/loop 0-9999
// [RULE23] power-on clear only 0 or 1, echoed
// [RULE24] step limits, auto-run and connect flags echoed
// [RULE25] event summary is event register AND enable
// [RULE26] query error on empty read or lost reply
// [RULE27] unknown header raises command error
module status_cmd_core #(
	parameter int VAL_W = 16
) (
	// clock and reset
	input  wire logic                     CLK,
	input  wire logic                     RST_B,
	// decoded command in
	input  wire logic                     CMD_VALID,
	input  wire status_cmd_pkg::cmd_t     CMD,
	// output queue
	input  wire logic                     RSP_TAKE,
	output logic [VAL_W-1:0]              RSP_DATA,
	output logic                          MSG_AVAIL,
	// device events and pins
	input  wire logic                     OUTPUT_ON_DONE,
	input  wire logic                     DEVICE_FAULT,
	input  wire logic                     MEM_CHECK_FAIL,
	// status view
	output logic [7:0]                    STATUS_BYTE,
	output logic                          SERVICE_REQ,
	// decoded system control
	output logic                          EXT_CTRL_EN,
	output logic [1:0]                    ANALOG_SEL,
	output logic                          AUTO_ADJUST_EN,
	output logic [1:0]                    POWER_UP_MODE,
	output logic                          AUTO_RUN,
	output logic                          OUTPUT_CONNECT
);

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0]       esr_ff;
	logic [7:0]       ese_ff;
	logic [7:0]       sre_ff;
	logic             psc_ff;
	logic             opc_armed_ff;
	logic             rqs_ff;
	logic             summary_d_ff;
	logic             mav_ff;
	logic [VAL_W-1:0] rsp_ff;
	logic [7:0]       stb_ff;
	logic [7:0]       stb_now;
	logic [1:0]       mem_sync_ff;
	logic [VAL_W-1:0] set_val [status_cmd_pkg::NUM_SET];
	logic [status_cmd_pkg::NUM_SET-1:0] set_bad;

	// ************************************************************
	// command decode
	// ************************************************************
	function automatic logic is_op(input status_cmd_pkg::cmd_t c, input status_cmd_pkg::op_t o);
		is_op = (c.op == o);
	endfunction

	wire cmd_q       = CMD_VALID && CMD.query;
	wire cmd_w       = CMD_VALID && !CMD.query;
	wire do_cls      = cmd_w && is_op(CMD, status_cmd_pkg::OP_CLEAR_STATUS);
	wire do_opc      = cmd_w && is_op(CMD, status_cmd_pkg::OP_OPC_ARM);
	wire do_rst      = cmd_w && is_op(CMD, status_cmd_pkg::OP_RESET);
	wire wr_ese      = cmd_w && is_op(CMD, status_cmd_pkg::OP_EVENT_ENABLE);
	wire wr_sre      = cmd_w && is_op(CMD, status_cmd_pkg::OP_SRQ_ENABLE);
	wire wr_psc      = cmd_w && is_op(CMD, status_cmd_pkg::OP_PON_CLEAR);
	wire set_sel_ok  = (CMD.sel < 5'(status_cmd_pkg::NUM_SET));
	wire wr_set      = cmd_w && is_op(CMD, status_cmd_pkg::OP_SETTING) && set_sel_ok;
	wire rd_esr      = cmd_q && is_op(CMD, status_cmd_pkg::OP_EVENT_STATUS);

	// ************************************************************
	// setting store
	// ************************************************************
	// loop rate takes only three discrete values, not a plain range
	wire loop_rate_select_ok = (CMD.arg == status_cmd_pkg::LOOP_RATE_SELECT_A) || (CMD.arg == status_cmd_pkg::LOOP_RATE_SELECT_B)
		|| (CMD.arg == status_cmd_pkg::LOOP_RATE_SELECT_C);

	// [RULE20] [RULE21] [RULE22] [RULE24] range-checked fields
	genvar gi;
	generate
		for (gi = 0; gi < status_cmd_pkg::NUM_SET; gi++) begin : g_set
			setting_field #(
				.W       (VAL_W),
				.MIN_VAL (status_cmd_pkg::SET_MIN[gi]),
				.MAX_VAL (status_cmd_pkg::SET_MAX[gi]),
				.RST_VAL (status_cmd_pkg::SET_RESET[gi])
			) u_field (
				.clk      (CLK),
				.rst_b    (RST_B),
				.wr       (wr_set && (CMD.sel == 5'(gi))),
				.defaults (do_rst),
				.extra_ok ((gi == status_cmd_pkg::S_LOOP_RATE_SELECT) ? loop_rate_select_ok : 1'b1),
				.arg      (CMD.arg),
				.value_ff (set_val[gi]),
				.bad      (set_bad[gi])
			);
		end
	endgenerate

	// ************************************************************
	// error classification
	// ************************************************************
	// [RULE27] unknown header or setting index
	logic cmd_known;
	always_comb begin
		case (CMD.op)
			status_cmd_pkg::OP_SETTING:      cmd_known = set_sel_ok;
			status_cmd_pkg::OP_SELF_TEST,
			status_cmd_pkg::OP_OPC_QUERY,
			status_cmd_pkg::OP_STATUS_BYTE,
			status_cmd_pkg::OP_EVENT_STATUS: cmd_known = CMD.query;
			status_cmd_pkg::OP_CLEAR_STATUS,
			status_cmd_pkg::OP_OPC_ARM,
			status_cmd_pkg::OP_WAIT,
			status_cmd_pkg::OP_RESET:        cmd_known = !CMD.query;
			status_cmd_pkg::OP_EVENT_ENABLE,
			status_cmd_pkg::OP_SRQ_ENABLE,
			status_cmd_pkg::OP_PON_CLEAR:    cmd_known = 1'b1;
			default:                         cmd_known = 1'b0;
		endcase
	end
	wire cmd_err = CMD_VALID && !cmd_known;

	// [RULE12] [RULE18] [RULE23] oversized mask or flag writes fail
	wire mask_bad = (wr_ese || wr_sre) && (CMD.arg > 16'h00FF);
	wire psc_bad  = wr_psc && (CMD.arg > 16'h0001);
	wire exec_err = (|set_bad) || mask_bad || psc_bad;

	// ************************************************************
	// reply selection
	// ************************************************************
	logic [VAL_W-1:0] reply;
	always_comb begin
		case (CMD.op)
			// [RULE1] self-test answer
			status_cmd_pkg::OP_SELF_TEST:    reply = mem_sync_ff[1] ? status_cmd_pkg::TST_MEM_FAIL
									: status_cmd_pkg::TST_PASS;
			status_cmd_pkg::OP_OPC_QUERY:    reply = status_cmd_pkg::OPC_DONE_REPLY;
			// [RULE5] [RULE6] event byte, unused bits masked
			status_cmd_pkg::OP_EVENT_STATUS: reply = VAL_W'(esr_ff & status_cmd_pkg::ESR_USED_MASK);
			// [RULE13] stored event mask
			status_cmd_pkg::OP_EVENT_ENABLE: reply = VAL_W'(ese_ff);
			// [RULE17] live status byte
			status_cmd_pkg::OP_STATUS_BYTE:  reply = VAL_W'(stb_now);
			// [RULE19] stored service mask
			status_cmd_pkg::OP_SRQ_ENABLE:   reply = VAL_W'(sre_ff);
			// [RULE23] power-on clear flag
			status_cmd_pkg::OP_PON_CLEAR:    reply = VAL_W'(psc_ff);
			status_cmd_pkg::OP_SETTING:      reply = set_sel_ok ? set_val[CMD.sel] : '0;
			default:                         reply = '0;
		endcase
	end
	wire push = cmd_q && cmd_known;

	// ************************************************************
	// output queue, one entry
	// ************************************************************
	// [RULE26] empty read or overwrite of an unread reply
	wire pop       = RSP_TAKE && mav_ff;
	wire query_err = (RSP_TAKE && !mav_ff) || (push && mav_ff && !RSP_TAKE);
	wire nxt_mav   = push || (mav_ff && !pop);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mav_ff <= 1'b0;
			rsp_ff <= '0;
		end else begin
			mav_ff <= nxt_mav;
			if (push)
				rsp_ff <= reply;
		end
	end

	// ************************************************************
	// event status register
	// ************************************************************
	// [RULE4] operation complete once armed and output power-on done
	wire opc_event = opc_armed_ff && OUTPUT_ON_DONE;
	logic [7:0] esr_set;
	always_comb begin
		esr_set = 8'h00;
		esr_set[status_cmd_pkg::ESR_OPC_BIT]   = opc_event;
		// [RULE7] query error bit
		esr_set[status_cmd_pkg::ESR_QUERY_BIT] = query_err;
		// [RULE8] device error bit
		esr_set[status_cmd_pkg::ESR_DEV_BIT]   = DEVICE_FAULT;
		// [RULE9] execution error bit
		esr_set[status_cmd_pkg::ESR_EXEC_BIT]  = exec_err;
		// [RULE10] command error bit
		esr_set[status_cmd_pkg::ESR_CMD_BIT]   = cmd_err;
	end
	// [RULE2] clear-status and the event query empty it; a new event wins
	wire esr_clr = do_cls || rd_esr;
	wire [7:0] nxt_esr = ((esr_clr ? 8'h00 : esr_ff) | esr_set) & status_cmd_pkg::ESR_USED_MASK;

	// [RULE11] power-on bit is the reset value of the register
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			esr_ff <= status_cmd_pkg::ESR_RESET;
		else
			esr_ff <= nxt_esr;
	end

	// operation-complete arming: clear-status or completion disarms
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			opc_armed_ff <= 1'b0;
		else if (do_opc)
			opc_armed_ff <= 1'b1;
		else if (opc_event || do_cls)
			opc_armed_ff <= 1'b0;
	end

	// ************************************************************
	// enable masks and power-on clear flag
	// ************************************************************
	// [RULE12] [RULE18] [RULE23] stored on a good write only
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ese_ff <= status_cmd_pkg::ESE_RESET;
			sre_ff <= status_cmd_pkg::SRE_RESET;
			psc_ff <= status_cmd_pkg::PSC_RESET;
		end else begin
			if (wr_ese && !mask_bad)
				ese_ff <= CMD.arg[7:0];
			if (wr_sre && !mask_bad)
				sre_ff <= CMD.arg[7:0];
			if (wr_psc && !psc_bad)
				psc_ff <= CMD.arg[0];
		end
	end

	// ************************************************************
	// status byte
	// ************************************************************
	// [RULE25] summary of enabled events
	wire esb = |(esr_ff & ese_ff & status_cmd_pkg::ESR_USED_MASK);
	// bit 6 of the enable is ignored, as the summary cannot request itself
	wire [7:0] stb_src = {1'b0, 1'b0, esb, mav_ff, 4'h0};
	wire rqs_summary   = |(stb_src & sre_ff);
	// [RULE14] [RULE15] [RULE16] [RULE17] bit placement
	assign stb_now = {1'b0, rqs_ff, esb, mav_ff, 4'h0};

	// [RULE3] clear-status drops the pending request; a fresh rise wins
	wire rqs_rise = rqs_summary && !summary_d_ff;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rqs_ff       <= 1'b0;
			summary_d_ff <= 1'b0;
			stb_ff       <= 8'h00;
		end else begin
			summary_d_ff <= rqs_summary;
			if (rqs_rise)
				rqs_ff <= 1'b1;
			else if (do_cls || !rqs_summary)
				rqs_ff <= 1'b0;
			stb_ff <= stb_now;
		end
	end

	// ************************************************************
	// pin synchroniser
	// ************************************************************
	// memory check result comes from outside this clock
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			mem_sync_ff <= 2'b00;
		else
			mem_sync_ff <= {mem_sync_ff[0], MEM_CHECK_FAIL};
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign RSP_DATA       = rsp_ff;
	assign MSG_AVAIL      = mav_ff;
	assign STATUS_BYTE    = stb_ff;
	assign SERVICE_REQ    = rqs_ff;
	// [RULE20] system-control codes
	assign EXT_CTRL_EN    = set_val[status_cmd_pkg::S_EXT_CTRL][0];
	assign ANALOG_SEL     = set_val[status_cmd_pkg::S_ANALOG][1:0];
	assign AUTO_ADJUST_EN = set_val[status_cmd_pkg::S_ADJ][0];
	assign POWER_UP_MODE  = set_val[status_cmd_pkg::S_PWRUP][1:0];
	assign AUTO_RUN       = set_val[status_cmd_pkg::S_AUTORUN][0];
	assign OUTPUT_CONNECT = set_val[status_cmd_pkg::S_CONNECT][0];

endmodule // status_cmd_core

// ==== rtl/setting_field_note.sv ====
// holds no logic

// ==== bench/status_cmd_sva.sv ====
// port assertions of the status and command block
module status_cmd_sva #(
	parameter int VAL_W = 16
) (
	// clock and reset
	input wire logic                 CLK,
	input wire logic                 RST_B,
	// command and reply side
	input wire logic                 CMD_VALID,
	input wire status_cmd_pkg::cmd_t CMD,
	input wire logic                 RSP_TAKE,
	input wire logic [VAL_W-1:0]     RSP_DATA,
	input wire logic                 MSG_AVAIL,
	// status and decoded settings
	input wire logic                 MEM_CHECK_FAIL,
	input wire logic [7:0]           STATUS_BYTE,
	input wire logic                 SERVICE_REQ,
	input wire logic                 EXT_CTRL_EN,
	input wire logic [1:0]           POWER_UP_MODE,
	input wire logic                 AUTO_RUN
);
	// ************************************************************
	// helper decode
	// ************************************************************
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	wire logic rd_c   = CMD_VALID && CMD.query;
	wire logic set_w  = CMD_VALID && !CMD.query && CMD.op == status_cmd_pkg::OP_SETTING;
	wire logic esr_q  = rd_c && CMD.op == status_cmd_pkg::OP_EVENT_STATUS;
	wire logic byte_q = rd_c && (CMD.op inside {status_cmd_pkg::OP_EVENT_STATUS,
		status_cmd_pkg::OP_EVENT_ENABLE, status_cmd_pkg::OP_STATUS_BYTE,
		status_cmd_pkg::OP_SRQ_ENABLE});
	logic [2:0] up_ff;
	// cycles since reset: the pin synchroniser is not trusted before it fills
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			up_ff <= 3'h0;
		else if (up_ff != 3'h7)
			up_ff <= up_ff + 3'h1;
	end

	// ************************************************************
	// assertions
	// ************************************************************
	// byte wide replies
	a_byte_reply: assert property (byte_q |=> MSG_AVAIL && RSP_DATA[VAL_W-1:8] == '0)
		else $error("byte query reply missing or too wide");
	a_esr_unused: assert property (esr_q |=> !RSP_DATA[1] && !RSP_DATA[6])
		else $error("unused event bit read as one");
	a_stb_unassigned: assert property (STATUS_BYTE[3:0] == 4'h0 && !STATUS_BYTE[7])
		else $error("unassigned status byte bit set");
	a_mav_shown: assert property (STATUS_BYTE[4] == $past(MSG_AVAIL))
		else $error("message available bit wrong");
	a_take_empties: assert property (RSP_TAKE && MSG_AVAIL && !rd_c |=> !MSG_AVAIL)
		else $error("reply still waiting after take");
	a_cls_drops: assert property (CMD_VALID && !CMD.query
		&& CMD.op == status_cmd_pkg::OP_CLEAR_STATUS |=> ##[0:1] !SERVICE_REQ)
		else $error("service request survived clear status");
	a_selftest_reply: assert property (rd_c && CMD.op == status_cmd_pkg::OP_SELF_TEST
		&& up_ff == 3'h7 && $past(MEM_CHECK_FAIL) == MEM_CHECK_FAIL
		&& $past(MEM_CHECK_FAIL, 2) == MEM_CHECK_FAIL && $past(MEM_CHECK_FAIL, 3) == MEM_CHECK_FAIL
		|=> RSP_DATA == VAL_W'($past(MEM_CHECK_FAIL)))
		else $error("self test reply wrong");
	a_ctrl_decode: assert property (set_w && CMD.sel == 5'(status_cmd_pkg::S_EXT_CTRL)
		&& CMD.arg <= 16'h0001 |=> ##1 EXT_CTRL_EN == $past(CMD.arg[0], 2))
		else $error("external control output not updated");
	a_pwrup_decode: assert property (set_w && CMD.sel == 5'(status_cmd_pkg::S_PWRUP)
		&& CMD.arg <= 16'h0002 |=> ##1 POWER_UP_MODE == $past(CMD.arg[1:0], 2))
		else $error("power up mode output not updated");
	a_autorun_decode: assert property (set_w && CMD.sel == 5'(status_cmd_pkg::S_AUTORUN)
		&& CMD.arg <= 16'h0001 |=> ##1 AUTO_RUN == $past(CMD.arg[0], 2))
		else $error("auto run output not updated");
endmodule // status_cmd_sva

bind status_cmd_core status_cmd_sva #(.VAL_W(VAL_W)) status_cmd_sva_inst (
	.CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD(CMD), .RSP_TAKE(RSP_TAKE),
	.RSP_DATA(RSP_DATA), .MSG_AVAIL(MSG_AVAIL), .MEM_CHECK_FAIL(MEM_CHECK_FAIL),
	.STATUS_BYTE(STATUS_BYTE), .SERVICE_REQ(SERVICE_REQ), .EXT_CTRL_EN(EXT_CTRL_EN),
	.POWER_UP_MODE(POWER_UP_MODE), .AUTO_RUN(AUTO_RUN));

// ==== bench/bus_ctrl_model.sv ====
// controller model that sends commands and reads replies
module bus_ctrl_model (
	// clock
	input  wire logic            clk,
	// command side
	output logic                 cmd_valid,
	output status_cmd_pkg::cmd_t cmd,
	// reply side
	input  wire logic            msg_avail,
	output logic                 rsp_take
);
	timeunit 1ns;
	timeprecision 100ps;
	int   lag      = 0;
	int   wait_cnt = 0;
	logic poke     = 1'b0;

	initial begin
		cmd_valid = 1'b0;
		cmd       = '0;
		rsp_take  = 1'b0;
	end
	// reader waits lag cycles, so a reply must stand until it is taken
	always @(posedge clk) begin
		wait_cnt <= (msg_avail && !rsp_take) ? wait_cnt + 1 : 0;
		rsp_take <= (msg_avail && !rsp_take && wait_cnt >= lag) || poke;
	end
	// one command, valid for exactly one edge, then garbage on the bus
	task automatic send(status_cmd_pkg::op_t op, logic q, logic [4:0] sel, logic [15:0] arg);
		logic [15:0] a;
		a = arg;
		if (op inside {status_cmd_pkg::OP_EVENT_ENABLE, status_cmd_pkg::OP_SRQ_ENABLE})
			a = {8'h00, arg[7:0]};
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd       <= '{op: op, query: q, sel: sel, arg: a};
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd       <= status_cmd_pkg::cmd_t'(~cmd);
	endtask
	// a take with nothing waiting
	task automatic poke_take();
		@(posedge clk);
		poke <= 1'b1;
		@(posedge clk);
		poke <= 1'b0;
	endtask
endmodule // bus_ctrl_model

// ==== bench/gpib_instrument_status_commands_test.sv ====
// self-checking bench of the status and command block
module gpib_instrument_status_commands_test;
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// signals and design
	// ************************************************************
	logic                 CLK            = 1'b0;
	logic                 RST_B          = 1'b0;
	logic                 OUTPUT_ON_DONE = 1'b0;
	logic                 DEVICE_FAULT   = 1'b0;
	logic                 MEM_CHECK_FAIL = 1'b0;
	logic                 CMD_VALID, RSP_TAKE, MSG_AVAIL, SERVICE_REQ;
	logic                 EXT_CTRL_EN, AUTO_ADJUST_EN, AUTO_RUN, OUTPUT_CONNECT;
	logic [1:0]           ANALOG_SEL, POWER_UP_MODE;
	logic [7:0]           STATUS_BYTE;
	logic [15:0]          RSP_DATA, v;
	status_cmd_pkg::cmd_t CMD;
	status_cmd_pkg::op_t  op;
	int                   n_errors  = 0;
	int                   cmp_count = 0;
	int                   seed      = 32'h4140093f;
	int                   r, span;
	logic [15:0]          exp_q [$];
	logic [15:0]          exp_set [25];
	logic [15:0]          rates [3] = '{16'h0001, 16'h000A, 16'h0064};
	logic [15:0]          ev_bits [5] = '{16'h0001, 16'h0004, 16'h0008, 16'h0010, 16'h0020};

	status_cmd_core status_cmd_core_inst (.CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID),
		.CMD(CMD), .RSP_TAKE(RSP_TAKE), .RSP_DATA(RSP_DATA), .MSG_AVAIL(MSG_AVAIL),
		.OUTPUT_ON_DONE(OUTPUT_ON_DONE), .DEVICE_FAULT(DEVICE_FAULT),
		.MEM_CHECK_FAIL(MEM_CHECK_FAIL), .STATUS_BYTE(STATUS_BYTE), .SERVICE_REQ(SERVICE_REQ),
		.EXT_CTRL_EN(EXT_CTRL_EN), .ANALOG_SEL(ANALOG_SEL), .AUTO_ADJUST_EN(AUTO_ADJUST_EN),
		.POWER_UP_MODE(POWER_UP_MODE), .AUTO_RUN(AUTO_RUN), .OUTPUT_CONNECT(OUTPUT_CONNECT));
	bus_ctrl_model bus_ctrl_model_inst (.clk(CLK), .cmd_valid(CMD_VALID), .cmd(CMD),
		.msg_avail(MSG_AVAIL), .rsp_take(RSP_TAKE));

	// ************************************************************
	// helpers
	// ************************************************************
	initial begin
		forever #2 CLK = ~CLK;
	end
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (n_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// a reply is judged at the edge that takes it; a reply nobody expected meets x
	always @(posedge CLK) begin
		if (RST_B && MSG_AVAIL === 1'b1 && RSP_TAKE === 1'b1)
			check("reply", RSP_DATA, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
	end
	// query, note the expectation, wait boundedly for it to be taken
	task automatic ask(status_cmd_pkg::op_t qop, logic [4:0] sel, logic [15:0] exp);
		bit ok;
		ok = 1'b0;
		exp_q.push_back(exp);
		bus_ctrl_model_inst.send(qop, 1'b1, sel, 16'h0000);
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge CLK);
			ok = (exp_q.size() == 0);
		end
		if (!ok) begin
			n_errors++;
			complete_run();
		end
	endtask
	// write form of a command
	task automatic wr(status_cmd_pkg::op_t o, logic [4:0] s, logic [15:0] a);
		bus_ctrl_model_inst.send(o, 1'b0, s, a);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		repeat (16) @(posedge CLK);
		RST_B <= 1'b1;
		ask(status_cmd_pkg::OP_EVENT_STATUS, 5'h00, 16'h0080);
		ask(status_cmd_pkg::OP_EVENT_STATUS, 5'h00, 16'h0000);
		ask(status_cmd_pkg::OP_SELF_TEST, 5'h00, 16'h0000);
		MEM_CHECK_FAIL <= 1'b1;
		repeat (4) @(posedge CLK);
		ask(status_cmd_pkg::OP_SELF_TEST, 5'h00, 16'h0001);
		MEM_CHECK_FAIL <= 1'b0;
		ask(status_cmd_pkg::OP_OPC_QUERY, 5'h00, 16'h0001);
		// random masks written and read back
		for (int m = 0; m < 2; m++) begin
			v = 16'($random(seed) & 32'hff);
			op = m ? status_cmd_pkg::OP_SRQ_ENABLE : status_cmd_pkg::OP_EVENT_ENABLE;
			wr(op, 5'h00, v);
			ask(op, 5'h00, v);
		end
		// every setting stored and echoed, reader lag varied
		for (int s = 0; s < status_cmd_pkg::NUM_SET; s++) begin
			r = $random(seed) & 32'h7fff_ffff;
			span = int'(status_cmd_pkg::SET_MAX[s]) - int'(status_cmd_pkg::SET_MIN[s]) + 1;
			v = status_cmd_pkg::SET_MIN[s] + 16'(r % span);
			if (s == status_cmd_pkg::S_LOOP_RATE_SELECT)
				v = rates[r % 3];
			exp_set[s] = v;
			bus_ctrl_model_inst.lag = s % 4;
			wr(status_cmd_pkg::OP_SETTING, 5'(s), v);
			ask(status_cmd_pkg::OP_SETTING, 5'(s), v);
		end
		bus_ctrl_model_inst.lag = 0;
		// every documented code of the selector settings
		for (int c = 0; c < 4; c++) begin
			wr(status_cmd_pkg::OP_SETTING, 5'd1, 16'(c));
			wr(status_cmd_pkg::OP_SETTING, 5'd3, 16'(c % 3));
			wr(status_cmd_pkg::OP_SETTING, 5'd4, 16'(c % 3));
			wr(status_cmd_pkg::OP_SETTING, 5'd5, rates[c % 3]);
			ask(status_cmd_pkg::OP_SETTING, 5'd5, rates[c % 3]);
			ask(status_cmd_pkg::OP_SETTING, 5'd4, 16'(c % 3));
			check("analog", 16'(ANALOG_SEL), 16'(c));
			check("power up", 16'(POWER_UP_MODE), 16'(c % 3));
		end
		check("ext ctrl", 16'(EXT_CTRL_EN), 16'(exp_set[0][0]));
		check("adjust", 16'(AUTO_ADJUST_EN), 16'(exp_set[2][0]));
		check("auto run", 16'(AUTO_RUN), 16'(exp_set[11][0]));
		check("connect", 16'(OUTPUT_CONNECT), 16'(exp_set[24][0]));
		// power-on clear: value 2 refused, stored 1 kept
		wr(status_cmd_pkg::OP_PON_CLEAR, 5'h00, 16'h0001);
		wr(status_cmd_pkg::OP_PON_CLEAR, 5'h00, 16'h0002);
		ask(status_cmd_pkg::OP_PON_CLEAR, 5'h00, 16'h0001);
		ask(status_cmd_pkg::OP_EVENT_STATUS, 5'h00, 16'h0010);
		// each event cause lands on its own bit
		for (int e = 0; e < 5; e++) begin
			if (e == 0)
				wr(status_cmd_pkg::OP_OPC_ARM, 5'h00, 16'h0000);
			if (e == 1)
				bus_ctrl_model_inst.poke_take();
			if (e >= 3)
				wr(status_cmd_pkg::OP_SETTING, (e == 3) ? 5'd10 : 5'd25, 16'h0009);
			@(posedge CLK);
			OUTPUT_ON_DONE <= (e == 0);
			DEVICE_FAULT <= (e == 2);
			@(posedge CLK);
			OUTPUT_ON_DONE <= 1'b0;
			DEVICE_FAULT <= 1'b0;
			ask(status_cmd_pkg::OP_EVENT_STATUS, 5'h00, ev_bits[e]);
		end
		ask(status_cmd_pkg::OP_SETTING, 5'd10, exp_set[10]);
		wr(status_cmd_pkg::OP_RESET, 5'h00, 16'h0000);
		ask(status_cmd_pkg::OP_SETTING, 5'd10, status_cmd_pkg::SET_RESET[10]);
		// enabled device error raises a request, clear status drops it
		wr(status_cmd_pkg::OP_SRQ_ENABLE, 5'h00, 16'h0020);
		wr(status_cmd_pkg::OP_EVENT_ENABLE, 5'h00, 16'h0008);
		@(posedge CLK);
		DEVICE_FAULT <= 1'b1;
		@(posedge CLK);
		DEVICE_FAULT <= 1'b0;
		repeat (3) @(posedge CLK);
		check("service", 16'(SERVICE_REQ), 16'h0001);
		check("status", 16'(STATUS_BYTE), 16'h0060);
		ask(status_cmd_pkg::OP_STATUS_BYTE, 5'h00, 16'h0060);
		wr(status_cmd_pkg::OP_CLEAR_STATUS, 5'h00, 16'h0000);
		repeat (2) @(posedge CLK);
		check("service", 16'(SERVICE_REQ), 16'h0000);
		ask(status_cmd_pkg::OP_EVENT_STATUS, 5'h00, 16'h0000);
		complete_run();
	end
endmodule // gpib_instrument_status_commands_test
